// file: rtl/stopwatch_alarm_compare.sv
// Summary of operation
// - Alarms compare as BCD elapsed time only while stop-watch mode is selected.
// - Alarm1 bytes sit at 08h to 0Ch: seconds, minutes, three hour pairs.
// - Alarm2 bytes sit at 0Dh to 0Fh: minutes, low and high hour pairs.
// - Seconds and minutes bytes: tens in bits 6..4, units 3..0, bit 7 absent.
// - Hour bytes: upper BCD digit in bits 7..4, lower in bits 3..0.
// - Enable register 10h bits 7..5 enable alarm2 fields, reset to zero.
// - Enable register bits 4..0 enable alarm1 fields, each reset to zero.
// - Only enabled fields are compared; disabled fields are ignored.
// - Time incrementing into a full match sets that alarm's flag.
// - A flag stays set until software clears it.
// - A cleared flag sets again only at the next increment into a match.
// - Mask registers 29h and 2Ah route each alarm flag to each irq output.
// - Each irq output is either a pulse per match or a level following flags.
// - Pulse form fires on every new match even if the flag stays set.
// - Alarm1 spans seconds to 999 999 hours, alarm2 minutes to 9 999 hours.
`timescale 1ns/1ps
`default_nettype none

module stopwatch_alarm_compare
  import stopwatch_alarm_pkg::*;
(
  input  wire logic          MCLK_I,
  input  wire logic          RST_B_I,
  input  wire logic          ELAPSED_COUNTER_SELECT_I,
  input  wire logic          TICK_I,
  input  wire elapsed_time_t COUNT_I,
  input  wire logic [7:0]    REG_ADDR_I,
  input  wire logic          REG_WR_I,
  input  wire logic [7:0]    REG_WDATA_I,
  input  wire logic          REG_RD_I,
  output logic      [7:0]    REG_RDATA_O,
  output logic               FIRST_ALARM_FLAG_O,
  output logic               SECOND_ALARM_FLAG_O,
  output logic               IRQ_OUT_ONE_B_O,
  output logic               IRQ_OUT_TWO_B_O
);

  alarm_state_t state;
  alarm_state_t next_state;

  logic [7:0] en;
  logic [1:0] match_now;
  logic [1:0] alarm_event;
  logic [7:0] read_mux;
  logic [7:0] mask_sel;

  assign en = state.field_enables;

  // each enabled field must equal the counter; all-disabled alarms never fire
  always_comb begin
    match_now[0] = ELAPSED_COUNTER_SELECT_I && (|en[4:0]) &&
      (!en[FIRST_ALARM_SECONDS_ON_BIT]
        || (state.alarm1.seconds == (COUNT_I.seconds & SEXAGESIMAL_MASK))) &&
      (!en[FIRST_ALARM_MINUTES_ON_BIT]
        || (state.alarm1.minutes == (COUNT_I.minutes & SEXAGESIMAL_MASK))) &&
      (!en[FIRST_ALARM_LOW_HOURS_ON_BIT]
        || (state.alarm1.hours_low_pair == COUNT_I.hours_low_pair)) &&
      (!en[FIRST_ALARM_MID_HOURS_ON_BIT]
        || (state.alarm1.hours_mid_pair == COUNT_I.hours_mid_pair)) &&
      (!en[FIRST_ALARM_HIGH_HOURS_ON_BIT]
        || (state.alarm1.hours_high_pair == COUNT_I.hours_high_pair));
    match_now[1] = ELAPSED_COUNTER_SELECT_I && (|en[7:5]) &&
      (!en[SECOND_ALARM_MINUTES_ON_BIT]
        || (state.alarm2.minutes == (COUNT_I.minutes & SEXAGESIMAL_MASK))) &&
      (!en[SECOND_ALARM_LOW_HOURS_ON_BIT]
        || (state.alarm2.hours_low_pair == COUNT_I.hours_low_pair)) &&
      (!en[SECOND_ALARM_HIGH_HOURS_ON_BIT]
        || (state.alarm2.hours_high_pair == COUNT_I.hours_mid_pair));
    // a match that already held at the previous tick is not a new event
    alarm_event = {2{TICK_I}} & match_now & ~state.match_seen;
  end

  always_comb begin
    case (REG_ADDR_I)
      ALARM1_SECONDS_OFF:         read_mux = state.alarm1.seconds;
      ALARM1_MINUTES_OFF:         read_mux = state.alarm1.minutes;
      ALARM1_HOURS_LOW_PAIR_OFF:  read_mux = state.alarm1.hours_low_pair;
      ALARM1_HOURS_MID_PAIR_OFF:  read_mux = state.alarm1.hours_mid_pair;
      ALARM1_HOURS_HIGH_PAIR_OFF: read_mux = state.alarm1.hours_high_pair;
      ALARM2_MINUTES_OFF:         read_mux = state.alarm2.minutes;
      ALARM2_HOURS_LOW_PAIR_OFF:  read_mux = state.alarm2.hours_low_pair;
      ALARM2_HOURS_HIGH_PAIR_OFF: read_mux = state.alarm2.hours_high_pair;
      ALARM_FIELD_ENABLES_OFF:    read_mux = state.field_enables;
      IRQ_ONE_SOURCE_MASK_OFF:    read_mux = state.irq_one_source_mask;
      IRQ_TWO_SOURCE_MASK_OFF:    read_mux = state.irq_two_source_mask;
      ALARM_FLAGS_OFF:            read_mux = {6'h00, state.alarm_flags};
      default:                    read_mux = UNMAPPED_READ;
    endcase
  end

  always_comb begin
    next_state = state;
    if (REG_RD_I) begin
      next_state.read_data = read_mux;
    end
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ALARM1_SECONDS_OFF:
          next_state.alarm1.seconds = REG_WDATA_I & SEXAGESIMAL_MASK;
        ALARM1_MINUTES_OFF:
          next_state.alarm1.minutes = REG_WDATA_I & SEXAGESIMAL_MASK;
        ALARM1_HOURS_LOW_PAIR_OFF:
          next_state.alarm1.hours_low_pair = REG_WDATA_I;
        ALARM1_HOURS_MID_PAIR_OFF:
          next_state.alarm1.hours_mid_pair = REG_WDATA_I;
        ALARM1_HOURS_HIGH_PAIR_OFF:
          next_state.alarm1.hours_high_pair = REG_WDATA_I;
        ALARM2_MINUTES_OFF:
          next_state.alarm2.minutes = REG_WDATA_I & SEXAGESIMAL_MASK;
        ALARM2_HOURS_LOW_PAIR_OFF:
          next_state.alarm2.hours_low_pair = REG_WDATA_I;
        ALARM2_HOURS_HIGH_PAIR_OFF:
          next_state.alarm2.hours_high_pair = REG_WDATA_I;
        ALARM_FIELD_ENABLES_OFF:
          next_state.field_enables = REG_WDATA_I;
        IRQ_ONE_SOURCE_MASK_OFF:
          next_state.irq_one_source_mask = REG_WDATA_I;
        IRQ_TWO_SOURCE_MASK_OFF:
          next_state.irq_two_source_mask = REG_WDATA_I;
        // writing 0 clears a flag, writing 1 leaves it alone
        ALARM_FLAGS_OFF:
          next_state.alarm_flags = state.alarm_flags & REG_WDATA_I[1:0];
        default: ;
      endcase
    end
    if (TICK_I) begin
      next_state.match_seen = match_now;
    end
    // set after clear, so an event in the clearing cycle survives
    next_state.alarm_flags = next_state.alarm_flags | alarm_event;
    for (int i = 0; i < 2; i++) begin
      mask_sel = (i == 0) ? state.irq_one_source_mask : state.irq_two_source_mask;
      if (mask_sel[IRQ_PULSE_MODE_BIT]) begin
        next_state.irq_active[i] =
          (alarm_event[0] && mask_sel[FIRST_ALARM_TO_IRQ_BIT]) ||
          (alarm_event[1] && mask_sel[SECOND_ALARM_TO_IRQ_BIT]);
      end else begin
        next_state.irq_active[i] =
          (next_state.alarm_flags[FIRST_ALARM_FLAG_BIT] && mask_sel[FIRST_ALARM_TO_IRQ_BIT]) ||
          (next_state.alarm_flags[SECOND_ALARM_FLAG_BIT] && mask_sel[SECOND_ALARM_TO_IRQ_BIT]);
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state.alarm1              <= '0;
      state.alarm2              <= '0;
      state.field_enables       <= BYTE_RESET;
      state.irq_one_source_mask <= MASK_RESET;
      state.irq_two_source_mask <= MASK_RESET;
      state.alarm_flags         <= FLAGS_RESET;
      state.match_seen          <= 2'h0;
      state.irq_active          <= 2'h0;
      state.read_data           <= UNMAPPED_READ;
    end else begin
      state <= next_state;
    end
  end

  assign REG_RDATA_O         = state.read_data;
  assign FIRST_ALARM_FLAG_O  = state.alarm_flags[FIRST_ALARM_FLAG_BIT];
  assign SECOND_ALARM_FLAG_O = state.alarm_flags[SECOND_ALARM_FLAG_BIT];
  assign IRQ_OUT_ONE_B_O     = ~state.irq_active[0];
  assign IRQ_OUT_TWO_B_O     = ~state.irq_active[1];

endmodule : stopwatch_alarm_compare

`default_nettype wire

// file: rtl/stopwatch_alarm_pkg.sv
package stopwatch_alarm_pkg;

  // register offsets on the byte register port
  localparam logic [7:0] ALARM1_SECONDS_OFF         = 8'h08;
  localparam logic [7:0] ALARM1_MINUTES_OFF         = 8'h09;
  localparam logic [7:0] ALARM1_HOURS_LOW_PAIR_OFF  = 8'h0A;
  localparam logic [7:0] ALARM1_HOURS_MID_PAIR_OFF  = 8'h0B;
  localparam logic [7:0] ALARM1_HOURS_HIGH_PAIR_OFF = 8'h0C;
  localparam logic [7:0] ALARM2_MINUTES_OFF         = 8'h0D;
  localparam logic [7:0] ALARM2_HOURS_LOW_PAIR_OFF  = 8'h0E;
  localparam logic [7:0] ALARM2_HOURS_HIGH_PAIR_OFF = 8'h0F;
  localparam logic [7:0] ALARM_FIELD_ENABLES_OFF    = 8'h10;
  localparam logic [7:0] IRQ_ONE_SOURCE_MASK_OFF    = 8'h29;
  localparam logic [7:0] IRQ_TWO_SOURCE_MASK_OFF    = 8'h2A;
  localparam logic [7:0] ALARM_FLAGS_OFF            = 8'h30;

  // alarm_field_enables bit positions
  localparam int SECOND_ALARM_HIGH_HOURS_ON_BIT = 7;
  localparam int SECOND_ALARM_LOW_HOURS_ON_BIT  = 6;
  localparam int SECOND_ALARM_MINUTES_ON_BIT    = 5;
  localparam int FIRST_ALARM_HIGH_HOURS_ON_BIT  = 4;
  localparam int FIRST_ALARM_MID_HOURS_ON_BIT   = 3;
  localparam int FIRST_ALARM_LOW_HOURS_ON_BIT   = 2;
  localparam int FIRST_ALARM_MINUTES_ON_BIT     = 1;
  localparam int FIRST_ALARM_SECONDS_ON_BIT     = 0;

  // source mask bits, same layout in both irq mask registers
  localparam int FIRST_ALARM_TO_IRQ_BIT  = 0;
  localparam int SECOND_ALARM_TO_IRQ_BIT = 1;
  localparam int IRQ_PULSE_MODE_BIT      = 7;

  // flag register bit positions
  localparam int FIRST_ALARM_FLAG_BIT  = 0;
  localparam int SECOND_ALARM_FLAG_BIT = 1;

  // seconds and minutes bytes have no bit 7
  localparam logic [7:0] SEXAGESIMAL_MASK = 8'h7F;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;
  localparam logic [1:0] FLAGS_RESET      = 2'h0;

  // running elapsed-time counter, two BCD digits per byte
  typedef struct packed {
    logic [7:0] hours_high_pair;
    logic [7:0] hours_mid_pair;
    logic [7:0] hours_low_pair;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } elapsed_time_t;

  typedef struct packed {
    logic [7:0] hours_high_pair;
    logic [7:0] hours_low_pair;
    logic [7:0] minutes;
  } alarm2_time_t;

  typedef struct packed {
    elapsed_time_t alarm1;
    alarm2_time_t  alarm2;
    logic [7:0]    field_enables;
    logic [7:0]    irq_one_source_mask;
    logic [7:0]    irq_two_source_mask;
    logic [1:0]    alarm_flags;
    logic [1:0]    match_seen;
    logic [1:0]    irq_active;
    logic [7:0]    read_data;
  } alarm_state_t;

endpackage : stopwatch_alarm_pkg

// file: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk_i,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial {rd_o, wr_o, addr_o, wdata_o} = 18'h0;
  // idle bus shows inverted values so a stray sample cannot match by luck
  task automatic acc(input logic w, input logic [7:0] a, dv, output logic [7:0] q);
    @(negedge mclk_i);
    {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, dv};
    @(negedge mclk_i);
    {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~dv};
    q = rdata_i;
  endtask : acc
endmodule : host_model
`default_nettype wire

// file: verification/stopwatch_alarm_compare_test.sv
`timescale 1ns/1ps
`default_nettype none
module stopwatch_alarm_compare_test import stopwatch_alarm_pkg::*; ;
  logic          mclk = 0, rst_b = 0, sel = 1, tick = 0, rd, wr, f1, f2, i1, i2;
  logic [7:0]    addr, wdata, rdata, d;
  elapsed_time_t cnt = '0;
  int            error_cnt = 0, num_checks = 0, cyc = 0;
  logic [7:0]    ofs [11] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
                              8'h10, 8'h29, 8'h2A};
  stopwatch_alarm_compare u_dut (.MCLK_I(mclk), .RST_B_I(rst_b), .ELAPSED_COUNTER_SELECT_I(sel),
    .TICK_I(tick), .COUNT_I(cnt), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .FIRST_ALARM_FLAG_O(f1), .SECOND_ALARM_FLAG_O(f2),
    .IRQ_OUT_ONE_B_O(i1), .IRQ_OUT_TWO_B_O(i2));
  host_model u_host (.mclk_i(mclk), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, v);
    u_host.acc(1'b1, a, v, d);
  endtask : wrr
  task automatic rdc(input logic [7:0] a, e);
    u_host.acc(1'b0, a, 8'h00, d);
    chk(d, e, "read data");
  endtask : rdc
  // checks {first flag, second flag, irq one, irq two} one cycle after the tick edge
  task automatic tk(input elapsed_time_t c, input logic [3:0] e);
    @(negedge mclk);
    cnt = c;
    tick = 1;
    @(negedge mclk);
    tick = 0;
    chk({4'h0, f1, f2, i1, i2}, {4'h0, e}, "flags and irqs");
  endtask : tk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1;
    chk({4'h0, f1, f2, i1, i2}, 8'h03, "reset outputs");
    foreach (ofs[k]) rdc(ofs[k], 8'h00);
    foreach (ofs[k]) begin
      wrr(ofs[k], 8'h99);
      rdc(ofs[k], ofs[k] inside {8'h08, 8'h09, 8'h0D} ? 8'h19 : 8'h99);
    end
    wrr(8'h20, 8'h55);
    rdc(8'h20, 8'h00);
    $display("register map test done");
    wrr(8'h08, 8'h05);
    wrr(8'h10, 8'h01);
    wrr(8'h29, 8'h01);
    wrr(8'h2A, 8'h00);
    tk(40'h04, 4'h3);
    tk(40'h05, 4'h9);
    tk(40'h06, 4'h9);
    rdc(8'h30, 8'h01);
    wrr(8'h30, 8'hFE);
    tk(40'h07, 4'h3);
    tk(40'h05, 4'h9);
    wrr(8'h30, 8'hFE);
    tk(40'h05, 4'h3);
    sel = 0;
    tk(40'h06, 4'h3);
    tk(40'h05, 4'h3);
    sel = 1;
    wrr(8'h10, 8'h1F);
    tk(40'h99_99_98_19_05, 4'h3);
    tk(40'h99_99_99_19_05, 4'h9);
    wrr(8'h30, 8'hFE);
    wrr(8'h29, 8'h00);
    $display("alarm one test done");
    wrr(8'h0D, 8'h30);
    wrr(8'h0E, 8'h12);
    wrr(8'h0F, 8'h34);
    wrr(8'h10, 8'hE0);
    wrr(8'h2A, 8'h82);
    wrr(8'h29, 8'h02);
    tk(40'h00_34_12_29_00, 4'h3);
    tk(40'h00_34_12_30_00, 4'h4);
    @(negedge mclk);
    chk({7'h0, i2}, 8'h01, "pulse width");
    tk(40'h00_34_12_31_00, 4'h5);
    tk(40'h00_34_12_30_00, 4'h4);
    $display("alarm two test done");
    give_verdict();
  end
endmodule : stopwatch_alarm_compare_test
`default_nettype wire

// file: verification/stopwatch_alarm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module stopwatch_alarm_monitor (
  input wire logic       MCLK_I,
  input wire logic       RST_B_I,
  input wire logic       ELAPSED_COUNTER_SELECT_I,
  input wire logic       TICK_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       FIRST_ALARM_FLAG_O,
  input wire logic       SECOND_ALARM_FLAG_O,
  input wire logic       IRQ_OUT_ONE_B_O,
  input wire logic       IRQ_OUT_TWO_B_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  // any write to the flag register may clear, so stickiness is only claimed without one
  wire logic       flag_wr = REG_WR_I && REG_ADDR_I == 8'h30;
  wire logic [1:0] flags   = {SECOND_ALARM_FLAG_O, FIRST_ALARM_FLAG_O};
  a_unmapped_read: assert property (REG_RD_I && REG_ADDR_I == 8'h20 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_flag_readback: assert property (REG_RD_I && REG_ADDR_I == 8'h30 |=> REG_RDATA_O[1:0] == $past(flags))
    else $error("flag read mismatch");
  a_first_set_cause: assert property ($rose(FIRST_ALARM_FLAG_O) |-> $past(TICK_I) && $past(ELAPSED_COUNTER_SELECT_I))
    else $error("first flag set without tick");
  a_second_set_cause: assert property ($rose(SECOND_ALARM_FLAG_O) |-> $past(TICK_I) && $past(ELAPSED_COUNTER_SELECT_I))
    else $error("second flag set without tick");
  a_first_sticky: assert property (FIRST_ALARM_FLAG_O && !flag_wr |=> FIRST_ALARM_FLAG_O)
    else $error("first flag dropped");
  a_second_sticky: assert property (SECOND_ALARM_FLAG_O && !flag_wr |=> SECOND_ALARM_FLAG_O)
    else $error("second flag dropped");
  a_irq_one_cause: assert property (!IRQ_OUT_ONE_B_O |-> flags != 2'h0)
    else $error("irq one low with no flag");
  a_irq_two_cause: assert property ($fell(IRQ_OUT_TWO_B_O) |-> flags != 2'h0)
    else $error("irq two fell with no flag");
  c_first_set: cover property ($rose(FIRST_ALARM_FLAG_O));
  c_first_clear: cover property ($fell(FIRST_ALARM_FLAG_O));
  c_two_pulse: cover property ($fell(IRQ_OUT_TWO_B_O) ##1 $rose(IRQ_OUT_TWO_B_O));
endmodule : stopwatch_alarm_monitor
bind stopwatch_alarm_compare stopwatch_alarm_monitor u_monitor (.MCLK_I, .RST_B_I,
  .ELAPSED_COUNTER_SELECT_I, .TICK_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
  .FIRST_ALARM_FLAG_O, .SECOND_ALARM_FLAG_O, .IRQ_OUT_ONE_B_O, .IRQ_OUT_TWO_B_O);
`default_nettype wire
